// file: ioc_host.sv
// Host interrupt input: resolves the pin with a pull-up.
// Assumes the bench tells it the configured polarity and type.
`timescale 1ns/1ns
module ioc_host (
  input  wire pin_i, oe_i, pol_i, typ_i,
  output wire act_o);
  // A released line floats to the pull-up level
  wire lvl = oe_i ? pin_i : 1'b1;
  assign act_o = (typ_i & pol_i) ? lvl : !lvl;
endmodule

// file: ioc_map.vh
// Register map, field positions, reset values and timing for the
// interrupt output conditioner. Assumes a 10 MHz system clock.
`ifndef IOC_MAP_VH
`define IOC_MAP_VH
`define IOC_ADDR_CFG      8'h54
`define IOC_ADDR_STS      8'h58
`define IOC_ADDR_EN       8'h5c
`define IOC_ADDR_SRC      8'h60
`define IOC_ADDR_SRST     8'h64
`define IOC_F_IVL_HI      31
`define IOC_F_IVL_LO      24
`define IOC_F_CLR         14
`define IOC_F_ACT         13
`define IOC_F_MASTER      12
`define IOC_F_EN          8
`define IOC_F_POL         4
`define IOC_F_TYPE        0
`define IOC_RST_IVL       8'h00
`define IOC_CLK_HZ        10000000
`define IOC_STEP_US       10
`define IOC_STEP_CYC      ((`IOC_CLK_HZ / 1000000) * `IOC_STEP_US)
`endif

// file: ioc_top.v
// Interrupt output conditioner: Wishbone classic slave, source status
// and enables, hold-off timer and the pin driver.
// Assumes sources are synchronous to clk_i; the pin wire is resolved
// outside from irq_pin_o / irq_oe_o.
`timescale 1ns/1ns
`include "ioc_map.vh"
module ioc_top #(
  parameter NSRC = 8
) (
  input  wire            clk_i,
  input  wire            rst_i,
  input  wire            cyc_i,
  input  wire            stb_i,
  input  wire            we_i,
  input  wire [7:0]      adr_i,
  input  wire [3:0]      sel_i,
  input  wire [31:0]     dat_i,
  output reg  [31:0]     dat_o,
  output reg             ack_o,
  input  wire [NSRC-1:0] src_event_i,
  output reg             irq_pin_o,
  output reg             irq_oe_o
);
  localparam integer STEP_CYC_I = `IOC_STEP_CYC;
  localparam [15:0]  STEP_CYC   = STEP_CYC_I[15:0];

  reg  [7:0]      ivl_q;
  reg             en_q;
  reg             pol_q;
  reg             type_q;
  reg  [NSRC-1:0] sts_q;
  reg  [NSRC-1:0] ien_q;
  reg  [15:0]     pre_q;
  reg  [7:0]      cnt_q;
  reg             act_q;
  reg             asserted_q;
  reg             soft_q;
  wire            wr;
  wire            rd_req;
  wire            soft_rst;
  wire            master;
  wire            clr_req;
  wire            fwd;
  wire            drive;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode: one wait state, ack for any address, unmapped reads 0
  assign wr     = cyc_i & stb_i & we_i & ~ack_o;
  assign rd_req = cyc_i & stb_i & ~ack_o;

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= rd_req;
      dat_o <= 32'h0000_0000;
      if (rd_req && !we_i) begin
        case (adr_i)
          `IOC_ADDR_CFG: begin
            dat_o[`IOC_F_IVL_HI:`IOC_F_IVL_LO] <= ivl_q;
            dat_o[`IOC_F_ACT]    <= act_q;
            dat_o[`IOC_F_MASTER] <= master;
            dat_o[`IOC_F_EN]     <= en_q;
            dat_o[`IOC_F_POL]    <= pol_q;
            dat_o[`IOC_F_TYPE]   <= type_q;
          end
          `IOC_ADDR_STS: dat_o[NSRC-1:0] <= sts_q;
          `IOC_ADDR_EN:  dat_o[NSRC-1:0] <= ien_q;
          default:       dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Digital soft reset: a one-cycle pulse from a write of bit 0
  assign soft_rst = soft_q;
  always @(posedge clk_i) begin
    if (rst_i)
      soft_q <= 1'b0;
    else
      soft_q <= wr && adr_i == `IOC_ADDR_SRST && sel_i[0] && dat_i[0];
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration register
  assign clr_req = wr && adr_i == `IOC_ADDR_CFG && sel_i[1] &&
                   dat_i[`IOC_F_CLR];

  always @(posedge clk_i) begin
    if (rst_i) begin
      pol_q  <= 1'b0;
      type_q <= 1'b0;
    end else if (wr && adr_i == `IOC_ADDR_CFG && sel_i[0]) begin
      pol_q  <= dat_i[`IOC_F_POL];
      type_q <= dat_i[`IOC_F_TYPE];
    end
  end

  // Soft reset spares polarity and driver type on purpose
  always @(posedge clk_i) begin
    if (rst_i || soft_rst) begin
      ivl_q <= `IOC_RST_IVL;
      en_q  <= 1'b0;
      ien_q <= {NSRC{1'b0}};
    end else if (wr) begin
      if (adr_i == `IOC_ADDR_CFG && sel_i[3])
        ivl_q <= dat_i[`IOC_F_IVL_HI:`IOC_F_IVL_LO];
      if (adr_i == `IOC_ADDR_CFG && sel_i[1])
        en_q <= dat_i[`IOC_F_EN];
      if (adr_i == `IOC_ADDR_EN)
        ien_q <= dat_i[NSRC-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Source status: event sets win over a write-one clear
  always @(posedge clk_i) begin
    if (rst_i || soft_rst)
      sts_q <= {NSRC{1'b0}};
    else if (wr && adr_i == `IOC_ADDR_STS)
      sts_q <= (sts_q & ~dat_i[NSRC-1:0]) | src_event_i;
    else
      sts_q <= sts_q | src_event_i;
  end

  assign master = |(sts_q & ien_q);

  ////////////////////////////////////////////////////////////////////////
  // Hold-off timer
  always @(posedge clk_i) begin
    if (rst_i || soft_rst) begin
      pre_q      <= 16'h0000;
      cnt_q      <= 8'h00;
      act_q      <= 1'b0;
      asserted_q <= 1'b0;
    end else begin
      asserted_q <= drive;
      if (ivl_q == 8'h00) begin
        // Disabled: counter cleared, pending interrupt passes at once
        pre_q <= 16'h0000;
        cnt_q <= 8'h00;
        act_q <= 1'b0;
      end else if (clr_req || (asserted_q && !drive)) begin
        pre_q <= 16'h0000;
        cnt_q <= 8'h00;
        act_q <= 1'b1;
      end else if (act_q) begin
        if (pre_q == STEP_CYC - 16'h0001) begin
          pre_q <= 16'h0000;
          if (cnt_q + 8'h01 >= ivl_q) begin
            cnt_q <= 8'h00;
            act_q <= 1'b0;
          end else
            cnt_q <= cnt_q + 8'h01;
        end else
          pre_q <= pre_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin driver
  assign fwd   = master & ~act_q;
  assign drive = fwd & en_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_pin_o <= 1'b0;
      irq_oe_o  <= 1'b0;
    end else if (!type_q) begin
      irq_pin_o <= 1'b0;
      irq_oe_o  <= drive;
    end else begin
      irq_pin_o <= pol_q ? drive : ~drive;
      irq_oe_o  <= 1'b1;
    end
  end
endmodule

// file: ioc_top_assertions.sv
// Checker for ioc_top: bus handshake, pin shaping and hold-off.
// Assumes full-word writes, so sel_i is not modelled.
`timescale 1ns/1ns
module ioc_top_chk #(parameter NSRC = 8) (
  input wire            clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
  input wire [7:0]      adr_i,
  input wire [3:0]      sel_i,
  input wire [31:0]     dat_i, dat_o,
  input wire [NSRC-1:0] src_event_i,
  input wire            irq_pin_o, irq_oe_o);
  reg en_q, pol_q, typ_q, ivl_q;
  wire drv = typ_q ? (pol_q ? irq_pin_o : !irq_pin_o) : irq_oe_o;
  always @(posedge clk_i)
    if (rst_i) {ivl_q, en_q, pol_q, typ_q} <= 4'h0;
    else if (cyc_i && stb_i && we_i && !ack_o) begin
      if (adr_i == 8'h54)
        {ivl_q, en_q, pol_q, typ_q} <=
          {|dat_i[31:24], dat_i[8], dat_i[4], dat_i[0]};
      if (adr_i == 8'h64 && dat_i[0]) {ivl_q, en_q} <= 2'h0;
    end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  AST_ACK_RESP: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack");
  AST_UNMAP: assert property (ack_o && !we_i && adr_i == 8'h60
    |-> dat_o == 32'h0) else $error("unmapped read not zero");
  AST_CLR_SC: assert property (ack_o && !we_i && adr_i == 8'h54
    |-> !dat_o[14]) else $error("clear bit reads one");
  AST_EN_OFF: assert property (!en_q && $past(!en_q) |-> !drv)
    else $error("pin active while disabled");
  AST_PP: assert property (typ_q && $past(typ_q) |-> irq_oe_o)
    else $error("push-pull not driving");
  AST_OD: assert property (!typ_q && $past(!typ_q) |-> !irq_pin_o)
    else $error("open-drain drives high");
  AST_HOLD: assert property ($fell(drv) && ivl_q |=> !drv [*8])
    else $error("pin active inside hold-off");
endmodule
bind ioc_top ioc_top_chk #(.NSRC(NSRC)) u_chk (.*);

// file: ioc_top_tb.sv
// Testbench for ioc_top with the host pin model.
// Assumes one 10 MHz clock; addresses as in ioc_map.vh.
`timescale 1ns/1ns
module ioc_top_tb;
  reg clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, p = 0, t = 0;
  reg [7:0] adr_i = 0, src_event_i = 0, r = 8'h4b, e;
  reg [31:0] dat_i = 0, rd;
  wire [31:0] dat_o;
  wire ack_o, irq_pin_o, irq_oe_o, act;
  integer n_errors = 0, comparisons = 0, i;
  ioc_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .src_event_i(src_event_i),
    .irq_pin_o(irq_pin_o), .irq_oe_o(irq_oe_o));
  ioc_host host (.pin_i(irq_pin_o), .oe_i(irq_oe_o), .pol_i(p),
    .typ_i(t), .act_o(act));
  always #50 clk_i = ~clk_i;
  function [7:0] nx(input [7:0] v);
    nx = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task wb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
      @(posedge clk_i);
      while (!ack_o) @(posedge clk_i);
      rd = dat_o;
      {cyc_i, stb_i} <= 2'b00;
    end
  endtask
  task chk(input [31:0] g, input [31:0] x);
    begin
      comparisons = comparisons + 1;
      if (g !== x) begin
        n_errors = n_errors + 1;
        $display("[ERR] %0t got %h exp %h", $time, g, x);
      end
    end
  endtask
  task ev(input [7:0] v);
    begin
      @(posedge clk_i) src_event_i <= v;
      @(posedge clk_i) src_event_i <= 8'h00;
      repeat (3) @(posedge clk_i);
    end
  endtask
  task stop_test;
    begin
      if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (3000) @(posedge clk_i);
    n_errors = n_errors + 1;
    stop_test;
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 8'h54, 0); chk(rd, 0);
    for (i = 0; i < 4; i = i + 1) begin
      r = nx(r); e = r & nx(r);
      ev(r); wb(0, 8'h58, 0); chk(rd, {24'h0, r});
      wb(1, 8'h5c, {24'h0, e}); wb(0, 8'h54, 0);
      chk(rd[12], |e);
      wb(1, 8'h58, {24'h0, r}); wb(0, 8'h58, 0); chk(rd, 0);
    end
    p = 1; t = 1; wb(1, 8'h5c, 1); wb(1, 8'h54, 32'h01000111);
    ev(1); chk(act, 1);
    wb(1, 8'h58, 1); ev(1); chk(act, 0);
    wb(0, 8'h54, 0); chk(rd[13], 1);
    repeat (100) @(posedge clk_i); chk(act, 1);
    wb(1, 8'h58, 1); ev(1); repeat (50) @(posedge clk_i);
    wb(1, 8'h54, 32'h01004111); repeat (85) @(posedge clk_i);
    chk(act, 0);
    wb(1, 8'h54, 32'h00000111); ev(0); chk(act, 1);
    t = 0; wb(1, 8'h54, 32'h00000110); ev(0); chk(act, 1);
    wb(1, 8'h54, 32'h00000010); ev(0); chk(act, 0);
    wb(1, 8'h60, 32'h5); wb(0, 8'h60, 0); chk(rd, 0);
    wb(1, 8'h54, 32'h00000011); wb(1, 8'h64, 1);
    wb(0, 8'h54, 0); chk(rd, 32'h11);
    stop_test;
  end
endmodule
